// ==== mmbs_pkg.sv ====
// package: bus cycle states, request carrier and constants for the minimum-mode strobe block
package mmbs_pkg;

    // bus cycle state codes
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h2,
        ST_T3 = 3'h3,
        ST_TW = 3'h4,
        ST_T4 = 3'h5,
        ST_HOLD = 3'h6
    } mmbs_state_t;

    // kind of access requested by the core
    typedef enum logic [1:0] {
        KIND_READ = 2'h0,
        KIND_WRITE = 2'h1,
        KIND_INTR_ACK_STROBE_N = 2'h2
    } mmbs_kind_t;

    // one bus cycle request from the core
    typedef struct packed {
        logic is_io;
        mmbs_kind_t kind;
    } mmbs_req_t;

    // levels of the strobes when idle or released
    localparam logic STROBE_IDLE_N = 1'h1;
    localparam logic ALE_IDLE = 1'h0;
    localparam logic IOM_RESET = 1'h0;
    localparam logic OE_OFF = 1'h0;
    localparam logic OE_ON = 1'h1;

endpackage : mmbs_pkg

// ==== mmbs_ale_gen.sv ====
// address latch pulse generator: high during the clock low phase of T1
`timescale 1ns/1ps

module mmbs_ale_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // state of the bus cycle
    input wire logic in_t1,
    // pulse out
    output logic ale
);

    // sampled on the falling edge inside T1, so the pulse covers the low half of T1;
    // being a flop it can only drop at the next falling edge, half way into T2
    always_ff @(negedge clk) begin
        if (!rst_n) begin
            ale <= mmbs_pkg::ALE_IDLE;
        end else begin
            ale <= in_t1;
        end
    end

endmodule : mmbs_ale_gen

// ==== mmbs_strobes.sv ====
// minimum-mode bus strobe generator: io/mem select, write, interrupt acknowledge and address latch pulse
`timescale 1ns/1ps

// What this block does
// - The io/mem select is the inverse of the maximum-mode status bit 2.
// - The io/mem select is high for an io access and low for a memory access.
// - The io/mem select is valid from T1 of a cycle through that cycle's final T4.
// - The write strobe marks every write, and the io/mem select tells memory from io.
// - The low write strobe is held for T2, T3 and every wait state of a write cycle.
// - While the bus is granted away the write strobe is released and held at logic one.
// - The low interrupt acknowledge strobe acts as a read strobe in T2, T3 and wait states.
// - The address latch pulse is high during the clock low phase of T1 of each cycle.
// - When the grant acknowledge rises the control lines float in the same cycle.
// - The minimum-mode strobes work only while the min/max select is tied high.
module mmbs_strobes (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration strap
    input wire logic min_max_select,
    // request from the core
    input wire logic req_valid,
    input wire mmbs_pkg::mmbs_req_t req,
    output logic req_taken,
    // wait request, sampled in T3 and wait states
    input wire logic wait_req,
    // another master asks for the bus
    input wire logic hold_req,
    output logic bus_grant_ack,
    // control strobes, each but the address latch pulse with its output enable
    output logic io_mem_sel,
    output logic io_mem_sel_oe,
    output logic wr_strobe_n,
    output logic wr_strobe_n_oe,
    output logic intr_ack_strobe_n,
    output logic intr_ack_strobe_n_oe,
    output logic ale,
    // equivalent maximum-mode status bit, for observation
    output logic max_mode_status_bit2,
    // current bus state
    output mmbs_pkg::mmbs_state_t bus_state
);

    ////////////////////////////////////////////////////////////////////////////////
    mmbs_pkg::mmbs_state_t state_reg;
    mmbs_pkg::mmbs_state_t state_next;
    mmbs_pkg::mmbs_req_t cur_reg;
    logic min_mode;
    logic start;
    logic take;
    logic strobe_window;
    logic drive_next;

    assign min_mode = min_max_select;
    // a new cycle starts from idle, or straight after T4 when a request waits
    assign start = min_mode && req_valid && !hold_req;

    // the edge that moves the machine into T1 takes the request
    assign take = (state_next == mmbs_pkg::ST_T1) && (state_reg != mmbs_pkg::ST_T1);
    assign strobe_window = (state_next == mmbs_pkg::ST_T2) || (state_next == mmbs_pkg::ST_T3) ||
        (state_next == mmbs_pkg::ST_TW);
    // control lines float while the bus is granted away or the strap picks the other mode
    assign drive_next = (state_next != mmbs_pkg::ST_HOLD) && min_mode;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mmbs_pkg::ST_IDLE: begin
                if (hold_req) begin
                    state_next = mmbs_pkg::ST_HOLD;
                end else if (start) begin
                    state_next = mmbs_pkg::ST_T1;
                end
            end
            mmbs_pkg::ST_T1: state_next = mmbs_pkg::ST_T2;
            mmbs_pkg::ST_T2: state_next = mmbs_pkg::ST_T3;
            mmbs_pkg::ST_T3, mmbs_pkg::ST_TW: begin
                state_next = wait_req ? mmbs_pkg::ST_TW : mmbs_pkg::ST_T4;
            end
            mmbs_pkg::ST_T4: begin
                if (hold_req) begin
                    state_next = mmbs_pkg::ST_HOLD;
                end else if (start) begin
                    state_next = mmbs_pkg::ST_T1;
                end else begin
                    state_next = mmbs_pkg::ST_IDLE;
                end
            end
            mmbs_pkg::ST_HOLD: begin
                if (!hold_req) begin
                    state_next = mmbs_pkg::ST_IDLE;
                end
            end
            default: state_next = mmbs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= mmbs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // the request is copied as the cycle enters T1 and kept to its end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_reg <= '{is_io: mmbs_pkg::IOM_RESET, kind: mmbs_pkg::KIND_READ};
        end else if (take) begin
            cur_reg <= req;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_taken <= 1'h0;
        end else begin
            req_taken <= take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // io/mem select: presented while idle with a request waiting, else on the taking edge;
    // never moved inside a running cycle, so back to back it turns over at T1, not inside T4
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_mem_sel <= mmbs_pkg::IOM_RESET;
        end else if (start && (state_next == mmbs_pkg::ST_IDLE || take)) begin
            io_mem_sel <= req.is_io;
        end
    end

    // status bit moves on the same condition, so it never disagrees with the select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            max_mode_status_bit2 <= ~mmbs_pkg::IOM_RESET;
        end else if (start && (state_next == mmbs_pkg::ST_IDLE || take)) begin
            max_mode_status_bit2 <= ~req.is_io;
        end
    end

    // strobes: registered from the next state so they line up with it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_strobe_n <= mmbs_pkg::STROBE_IDLE_N;
        end else if (strobe_window && cur_reg.kind == mmbs_pkg::KIND_WRITE) begin
            wr_strobe_n <= 1'h0;
        end else begin
            wr_strobe_n <= mmbs_pkg::STROBE_IDLE_N;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intr_ack_strobe_n <= mmbs_pkg::STROBE_IDLE_N;
        end else if (strobe_window && cur_reg.kind == mmbs_pkg::KIND_INTR_ACK_STROBE_N) begin
            intr_ack_strobe_n <= 1'h0;
        end else begin
            intr_ack_strobe_n <= mmbs_pkg::STROBE_IDLE_N;
        end
    end

    // grant and release happen together; released strobes park at one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_grant_ack <= 1'h0;
        end else begin
            bus_grant_ack <= (state_next == mmbs_pkg::ST_HOLD);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_mem_sel_oe <= mmbs_pkg::OE_OFF;
        end else begin
            io_mem_sel_oe <= drive_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_strobe_n_oe <= mmbs_pkg::OE_OFF;
        end else begin
            wr_strobe_n_oe <= drive_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intr_ack_strobe_n_oe <= mmbs_pkg::OE_OFF;
        end else begin
            intr_ack_strobe_n_oe <= drive_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_state <= mmbs_pkg::ST_IDLE;
        end else begin
            bus_state <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the latch pulse is clocked off the falling edge to sit in the low phase
    mmbs_ale_gen u_ale (
        .clk(clk),
        .rst_n(rst_n),
        .in_t1(bus_state == mmbs_pkg::ST_T1),
        .ale(ale)
    );

endmodule : mmbs_strobes

// ==== mmbs_strobes_sva.sv ====
// checker: timing relations of the minimum-mode strobes
`timescale 1ns/1ps

module mmbs_strobes_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic wait_req,
    input wire logic bus_grant_ack,
    input wire logic io_mem_sel,
    input wire logic io_mem_sel_oe,
    input wire logic wr_strobe_n,
    input wire logic wr_strobe_n_oe,
    input wire logic intr_ack_strobe_n,
    input wire logic intr_ack_strobe_n_oe,
    input wire logic ale,
    input wire logic max_mode_status_bit2,
    input wire mmbs_pkg::mmbs_state_t bus_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_STATUS_INV: assert property (max_mode_status_bit2 == !io_mem_sel)
        else $error("status bit not inverse of select");
    AST_SEL_HELD: assert property (bus_state inside {mmbs_pkg::ST_T2, mmbs_pkg::ST_T3, mmbs_pkg::ST_TW, mmbs_pkg::ST_T4} |-> $stable(io_mem_sel))
        else $error("select moved inside a cycle");
    AST_WR_STATES: assert property (!wr_strobe_n |-> bus_state inside {mmbs_pkg::ST_T2, mmbs_pkg::ST_T3, mmbs_pkg::ST_TW})
        else $error("write strobe low outside T2 T3 TW");
    AST_INTR_ACK_STROBE_N_STATES: assert property (!intr_ack_strobe_n |-> bus_state inside {mmbs_pkg::ST_T2, mmbs_pkg::ST_T3, mmbs_pkg::ST_TW})
        else $error("acknowledge strobe low outside T2 T3 TW");
    AST_FLOAT: assert property (bus_grant_ack |-> !io_mem_sel_oe && !wr_strobe_n_oe && wr_strobe_n &&
        !intr_ack_strobe_n_oe && intr_ack_strobe_n)
        else $error("lines driven while bus granted");
    AST_ALE_T1: assert property (ale == (bus_state == mmbs_pkg::ST_T1))
        else $error("latch pulse not tied to T1");
    AST_SEQ: assert property (bus_state == mmbs_pkg::ST_T1 |=> bus_state == mmbs_pkg::ST_T2 ##1 bus_state == mmbs_pkg::ST_T3)
        else $error("cycle states out of order");
    AST_WAIT: assert property (bus_state inside {mmbs_pkg::ST_T3, mmbs_pkg::ST_TW} |=> bus_state == ($past(wait_req) ? mmbs_pkg::ST_TW : mmbs_pkg::ST_T4))
        else $error("wait state count wrong");
endmodule : mmbs_strobes_sva

bind mmbs_strobes mmbs_strobes_sva u_sva (.clk, .rst_n, .wait_req, .bus_grant_ack, .io_mem_sel, .io_mem_sel_oe,
    .wr_strobe_n, .wr_strobe_n_oe, .intr_ack_strobe_n, .intr_ack_strobe_n_oe, .ale, .max_mode_status_bit2,
    .bus_state);

// ==== mmbs_far_side.sv ====
// far side model: slow peripheral inserting wait states, and the outside address latch
`timescale 1ns/1ps

module mmbs_far_side (
    // clock
    input wire logic clk,
    // wait states wanted per strobed cycle
    input wire logic [3:0] n_waits,
    // lines from the block
    input wire logic ale,
    input wire logic io_mem_sel,
    input wire logic wr_strobe_n,
    input wire logic intr_ack_strobe_n,
    // answers
    output logic wait_req,
    output logic latched_io
);
    logic [3:0] low_cnt_reg;
    // only strobed cycles are stretched; reads carry no strobe here
    assign wait_req = (!wr_strobe_n || !intr_ack_strobe_n) && (low_cnt_reg <= n_waits);
    always_ff @(posedge clk) begin
        low_cnt_reg <= ale ? 4'h0 : low_cnt_reg + {3'h0, !wr_strobe_n || !intr_ack_strobe_n};
    end
    always_ff @(negedge ale) begin
        latched_io <= io_mem_sel;
    end
endmodule : mmbs_far_side

// ==== mmbs_strobes_bench.sv ====
// bench: write, acknowledge, read, hold and mode cases of the strobe block
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, a); end end

module mmbs_strobes_bench;
    logic clk = 1'h0, rst_n = 1'h0, min_max_select = 1'h1, req_valid = 1'h0, hold_req = 1'h0;
    logic wait_req, req_taken, bus_grant_ack, io_mem_sel, io_mem_sel_oe, wr_strobe_n, wr_strobe_n_oe;
    logic intr_ack_strobe_n, intr_ack_strobe_n_oe, ale, max_mode_status_bit2, wr_line, ia_line, latched_io;
    logic [3:0] n_waits = 4'h0;
    mmbs_pkg::mmbs_req_t req = 3'h0;
    mmbs_pkg::mmbs_state_t bus_state;
    int fail_count = 0, tests_run = 0;
    // released strobes are held at logic one on the wire
    assign wr_line = wr_strobe_n_oe ? wr_strobe_n : 1'h1;
    assign ia_line = intr_ack_strobe_n_oe ? intr_ack_strobe_n : 1'h1;
    mmbs_strobes u_dut (.clk, .rst_n, .min_max_select, .req_valid, .req, .req_taken, .wait_req, .hold_req,
        .bus_grant_ack, .io_mem_sel, .io_mem_sel_oe, .wr_strobe_n, .wr_strobe_n_oe, .intr_ack_strobe_n,
        .intr_ack_strobe_n_oe, .ale, .max_mode_status_bit2, .bus_state);
    mmbs_far_side u_far (.clk, .n_waits, .ale, .io_mem_sel, .wr_strobe_n(wr_line), .intr_ack_strobe_n(ia_line),
        .wait_req, .latched_io);
    initial begin
        forever #20 clk = !clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic run_cycle(input mmbs_pkg::mmbs_kind_t kind, input logic io, input logic [3:0] waits);
        int n;
        n_waits = waits;
        req = {io, kind};
        req_valid = 1'h1;
        for (n = 0; bus_state !== mmbs_pkg::ST_T1; n++) begin
            if (n == 20) begin
                fail_count++;
                give_verdict();
            end
            @(negedge clk);
        end
        req_valid = 1'h0;
        `CHK("taken", 1'h1, req_taken)
        `CHK("select", io, io_mem_sel)
        `CHK("status", !io, max_mode_status_bit2)
        #1;
        `CHK("latch pulse", 1'h1, ale)
        for (n = 0; n < waits + 2; n++) begin
            @(negedge clk);
            `CHK("write", kind != mmbs_pkg::KIND_WRITE, wr_strobe_n)
            `CHK("intr_ack_strobe_n", kind != mmbs_pkg::KIND_INTR_ACK_STROBE_N, intr_ack_strobe_n)
        end
        @(negedge clk);
        `CHK("end", mmbs_pkg::ST_T4, bus_state)
        `CHK("select held", io, io_mem_sel)
        `CHK("latched", io, latched_io)
        `CHK("strobes off", 2'h3, {wr_strobe_n, intr_ack_strobe_n})
    endtask : run_cycle
    task automatic t_writes;
        run_cycle(mmbs_pkg::KIND_WRITE, 1'h0, 4'h0);
        run_cycle(mmbs_pkg::KIND_WRITE, 1'h1, 4'h2);
        $display("test writes done");
    endtask : t_writes
    task automatic t_intr_ack_strobe_n_read;
        run_cycle(mmbs_pkg::KIND_INTR_ACK_STROBE_N, 1'h1, 4'h1);
        run_cycle(mmbs_pkg::KIND_READ, 1'h0, 4'h0);
        run_cycle(mmbs_pkg::KIND_READ, 1'h1, 4'h0);
        $display("test acknowledge and read done");
    endtask : t_intr_ack_strobe_n_read
    task automatic t_hold;
        hold_req = 1'h1;
        req_valid = 1'h1;
        repeat (2) @(negedge clk);
        `CHK("grant", 1'h1, bus_grant_ack)
        `CHK("float", 3'h0, {io_mem_sel_oe, wr_strobe_n_oe, intr_ack_strobe_n_oe})
        `CHK("wr one", 1'h1, wr_line)
        `CHK("no take", 1'h0, req_taken)
        hold_req = 1'h0;
        run_cycle(mmbs_pkg::KIND_WRITE, 1'h1, 4'h0);
        $display("test hold done");
    endtask : t_hold
    task automatic t_mode;
        min_max_select = 1'h0;
        req_valid = 1'h1;
        repeat (3) @(negedge clk);
        `CHK("refused", 2'h0, {req_taken, wr_strobe_n_oe})
        req_valid = 1'h0;
        min_max_select = 1'h1;
        @(negedge clk);
        run_cycle(mmbs_pkg::KIND_INTR_ACK_STROBE_N, 1'h0, 4'h0);
        $display("test mode done");
    endtask : t_mode
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        t_writes();
        t_intr_ack_strobe_n_read();
        t_hold();
        t_mode();
        give_verdict();
    end
endmodule : mmbs_strobes_bench
